// File: rtl/epvs_pkg.sv
//==========================================================
// Notes on behaviour
// - Programmable priorities reset to value zero
// - Interrupt line n uses vector n+16
// - Lines 0-29 exist; 9 and 13 reserved
// - Word zero holds stack pointer, then handlers
// - Table base is zero after reset
// - Privileged writes relocate base up to 0x3FFFFF00
// - Smaller value wins; three exceptions fixed
// - Configurable priorities limited to 0-7
// - Equal priority: smallest exception number wins
// - Strictly higher group priority preempts running handler
// - Equal priority never preempts; stays pending
// - Priority splits into group and subpriority
// - Preemption compares group priority only
// - Subpriority then number orders equal groups
// - Hard fault -1, NMI -2, reset -3
package epvs_pkg;

  //==========================================================
  // Sizes
  localparam int NVEC = 46;
  localparam int NIRQ = 30;
  localparam int NSYS = 16;
  localparam int PRIO_W = 3;
  localparam int VEC_W = 6;

  //==========================================================
  // Vector numbers and ranks
  localparam logic [VEC_W-1:0] VEC_RESET = 6'h01;
  localparam logic [VEC_W-1:0] VEC_NMI = 6'h02;
  localparam logic [VEC_W-1:0] VEC_HARD = 6'h03;
  localparam logic [VEC_W-1:0] VEC_IRQ0 = 6'h10;
  localparam logic [3:0] RANK_RESET = 4'h0;
  localparam logic [3:0] RANK_NMI = 4'h1;
  localparam logic [3:0] RANK_HARD = 4'h2;
  localparam logic [3:0] RANK_CFG_BASE = 4'h3;

  // Vectors that can be raised, and those with writable priority
  localparam logic [NVEC-1:0] VALID_MASK = 46'h3FFF_DDFF_D87E;
  localparam logic [NVEC-1:0] PROG_MASK = 46'h3FFF_DDFF_D870;

  //==========================================================
  // Reset values and table base limits
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_FULL_MASK = 3'h7;
  localparam logic [1:0] SUB_BITS_RESET = 2'h0;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] BASE_MAX = 32'h3FFF_FF00;
  localparam logic [31:0] BASE_ALIGN_MASK = 32'hFFFF_FF00;
  localparam logic [31:0] ADDR_IRQ0 = 32'h0000_0040;

  //==========================================================
  // Carriers
  typedef struct packed {
    logic en;
    logic [VEC_W-1:0] vec;
    logic [PRIO_W-1:0] prio;
  } epvs_prio_wr_t;

  typedef struct packed {
    logic en;
    logic priv;
    logic [31:0] data;
  } epvs_base_wr_t;

  typedef struct packed {
    logic req;
    logic [VEC_W-1:0] vec;
    logic [31:0] addr;
  } epvs_exc_t;

  typedef struct packed {
    logic [NVEC-1:0] pend;
    logic [NVEC-1:0][PRIO_W-1:0] prio;
    logic [31:0] base;
    logic [1:0] subBits;
    epvs_exc_t exc;
  } epvs_state_t;

endpackage

// File: rtl/epvs_core.sv
`timescale 1ns/10ps
module epvs_core (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [epvs_pkg::NSYS-1:0] sysRaise,
  input wire logic [epvs_pkg::NIRQ-1:0] irqLines,
  input wire logic ackEn,
  input wire logic [epvs_pkg::VEC_W-1:0] ackVec,
  input wire logic handlerActive,
  input wire logic [epvs_pkg::VEC_W-1:0] activeVec,
  input wire epvs_pkg::epvs_prio_wr_t prioWr,
  input wire epvs_pkg::epvs_base_wr_t baseWr,
  input wire logic grpWrEn,
  input wire logic [1:0] grpWrSubBits,
  output epvs_pkg::epvs_exc_t excOut,
  output logic [31:0] stackPtrAddr,
  output logic [epvs_pkg::NVEC-1:0] pendingOut
);
  import epvs_pkg::*;

  //==========================================================
  // State
  epvs_state_t st_reg;
  epvs_state_t st_next;
  logic [NVEC-1:0] raise;
  logic [NVEC-1:0] clr;
  logic [PRIO_W-1:0] grpMask;
  logic found;
  logic [VEC_W-1:0] bestVec;
  logic [3:0] bestRank;
  logic [3:0] bestGrp;
  logic [3:0] actGrp;
  logic [PRIO_W-1:0] actPrio;

  // Rank: fixed exceptions sit below every configurable value
  function automatic logic [3:0] rankOf(input logic [VEC_W-1:0] v,
                                        input logic [PRIO_W-1:0] p,
                                        input logic [PRIO_W-1:0] m);
    logic [3:0] r;
    r = RANK_CFG_BASE + {1'b0, p & m};
    if (v == VEC_RESET) begin
      r = RANK_RESET;
    end else if (v == VEC_NMI) begin
      r = RANK_NMI;
    end else if (v == VEC_HARD) begin
      r = RANK_HARD;
    end
    return r;
  endfunction

  //==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    // line n lands on vector n+16
    raise = {irqLines, sysRaise} & VALID_MASK;
    clr = '0;
    if (ackEn && ackVec < VEC_W'(NVEC)) begin
      clr[ackVec] = 1'b1;
    end
    // pending kept until taken; a new raise beats the clear
    st_next.pend = (st_reg.pend & ~clr) | raise;

    // three-bit field bounds values to 0-7
    if (prioWr.en && prioWr.vec < VEC_W'(NVEC)) begin
      if (PROG_MASK[prioWr.vec]) begin
        st_next.prio[prioWr.vec] = prioWr.prio;
      end
    end

    // privileged, in-range writes move the base
    if (baseWr.en && baseWr.priv && baseWr.data <= BASE_MAX) begin
      st_next.base = baseWr.data & BASE_ALIGN_MASK; // Low byte dropped, stays aligned
    end

    // split point sets the subpriority width
    if (grpWrEn) begin
      st_next.subBits = grpWrSubBits;
    end
    grpMask = PRIO_FULL_MASK << st_reg.subBits;

    // ascending scan with strict compare keeps the lowest number
    // full value orders group, then subpriority
    found = 1'b0;
    bestVec = '0;
    bestRank = 4'hF;
    for (int v = 0; v < NVEC; v++) begin
      if (st_reg.pend[v]) begin
        if (!found || rankOf(VEC_W'(v), st_reg.prio[v], PRIO_FULL_MASK) < bestRank) begin
          found = 1'b1;
          bestVec = VEC_W'(v);
          bestRank = rankOf(VEC_W'(v), st_reg.prio[v], PRIO_FULL_MASK);
        end
      end
    end

    // preemption looks at group fields only
    actPrio = (activeVec < VEC_W'(NVEC)) ? st_reg.prio[activeVec] : PRIO_RESET;
    bestGrp = rankOf(bestVec, st_reg.prio[bestVec], grpMask);
    actGrp = rankOf(activeVec, actPrio, grpMask);

    // strictly higher group preempts; equal waits
    st_next.exc.req = found && (!handlerActive || bestGrp < actGrp);
    st_next.exc.vec = bestVec;
    st_next.exc.addr = st_reg.base + {24'h00_0000, bestVec, 2'b00};
  end

  //==========================================================
  // Registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg.pend <= '0;
      st_reg.prio <= {NVEC{PRIO_RESET}};
      // base back at zero on every reset
      st_reg.base <= BASE_RESET;
      st_reg.subBits <= SUB_BITS_RESET;
      st_reg.exc <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  //==========================================================
  // Outputs
  // stack word sits at the table base, handlers follow
  assign stackPtrAddr = st_reg.base;
  assign excOut = st_reg.exc;
  assign pendingOut = st_reg.pend;

  //==========================================================
  // Reference arbiter for the checks
  // Coded apart from the scan above (descending order, shifted group
  // fields) so that one slip cannot hide in both copies
  logic refFound;
  logic [VEC_W-1:0] refVec;
  logic [3:0] refKey;
  logic [3:0] refCand;
  logic [PRIO_W-1:0] refActPrio;
  logic [3:0] refBestGrp;
  logic [3:0] refActGrp;
  logic refReq;

  // Key: fixed exceptions first, then base rank plus the shifted priority
  function automatic logic [3:0] keyOf(input logic [VEC_W-1:0] v,
                                       input logic [PRIO_W-1:0] p,
                                       input logic [1:0] s);
    logic [3:0] k;
    k = RANK_CFG_BASE + {1'b0, p >> s};
    if (v == VEC_RESET) begin
      k = RANK_RESET;
    end else if (v == VEC_NMI) begin
      k = RANK_NMI;
    end else if (v == VEC_HARD) begin
      k = RANK_HARD;
    end
    return k;
  endfunction

  // Later, lower numbers take ties, so the lowest pending number wins
  always_comb begin
    refFound = 1'b0;
    refVec = '0;
    refKey = 4'hF;
    refCand = 4'hF;
    for (int v = NVEC - 1; v >= 0; v--) begin
      refCand = keyOf(VEC_W'(v), st_reg.prio[v], 2'h0);
      if (st_reg.pend[v] && refCand <= refKey) begin
        refFound = 1'b1;
        refVec = VEC_W'(v);
        refKey = refCand;
      end
    end
    // Out-of-range running vector counts as priority zero
    refActPrio = (activeVec < VEC_W'(NVEC)) ? st_reg.prio[activeVec] : PRIO_RESET;
    refBestGrp = keyOf(refVec, st_reg.prio[refVec], st_reg.subBits);
    refActGrp = keyOf(activeVec, refActPrio, st_reg.subBits);
    refReq = refFound && (!handlerActive || refBestGrp < refActGrp);
  end

  //==========================================================
  // Checks
  a_prio_reset: assert property (@(posedge clock)
    nrst && !$past(nrst) |-> st_reg.prio == '0)
    else $error("priority not zero after reset");

  a_base_reset: assert property (@(posedge clock)
    nrst && !$past(nrst) |-> st_reg.base == BASE_RESET)
    else $error("table base not zero after reset");

  a_irq_vector: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) && $past(irqLines[0]) |-> st_reg.pend[VEC_IRQ0])
    else $error("line 0 not pending on vector 16");

  a_irq0_addr: assert property (@(posedge clock) disable iff (!nrst)
    excOut.req && excOut.vec == VEC_IRQ0 |-> excOut.addr == $past(st_reg.base) + ADDR_IRQ0)
    else $error("line 0 vector address wrong");

  a_reserved_quiet: assert property (@(posedge clock) disable iff (!nrst)
    (pendingOut & ~VALID_MASK) == '0)
    else $error("reserved vector pending");

  a_vec_addr: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) |-> excOut.addr == $past(st_reg.base) + {24'h00_0000, excOut.vec, 2'b00})
    else $error("vector address mismatch");

  a_base_write: assert property (@(posedge clock) disable iff (!nrst)
    baseWr.en && baseWr.priv && baseWr.data <= BASE_MAX
    |=> st_reg.base == ($past(baseWr.data) & BASE_ALIGN_MASK))
    else $error("table base write lost");

  a_base_unpriv: assert property (@(posedge clock) disable iff (!nrst)
    baseWr.en && !baseWr.priv |=> $stable(st_reg.base))
    else $error("unprivileged base write took effect");

  a_fixed_prio: assert property (@(posedge clock) disable iff (!nrst)
    st_reg.prio[VEC_RESET] == PRIO_RESET && st_reg.prio[VEC_NMI] == PRIO_RESET
    && st_reg.prio[VEC_HARD] == PRIO_RESET)
    else $error("fixed priority changed");

  a_reset_first: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) && $past(st_reg.pend[VEC_RESET]) && !$past(handlerActive)
    |-> excOut.req && excOut.vec == VEC_RESET)
    else $error("reset exception not chosen first");

  a_nmi_over_cfg: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) && $past(st_reg.pend[VEC_NMI]) && !$past(handlerActive) |-> excOut.vec <= VEC_NMI)
    else $error("configurable exception beat NMI");

  a_tie_lowest: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) && $past(st_reg.pend[16]) && $past(st_reg.pend[17])
    && $past(st_reg.prio[16]) == $past(st_reg.prio[17]) |-> excOut.vec != 6'h11)
    else $error("higher number won a tie");

  a_no_equal_preempt: assert property (@(posedge clock) disable iff (!nrst)
    handlerActive && refBestGrp >= refActGrp |=> !excOut.req)
    else $error("equal group preempted handler");

  a_preempt_higher: assert property (@(posedge clock) disable iff (!nrst)
    handlerActive && refFound && refBestGrp < refActGrp
    |=> excOut.req && excOut.vec == $past(refVec))
    else $error("higher group did not preempt");

  a_split_write: assert property (@(posedge clock) disable iff (!nrst)
    grpWrEn |=> st_reg.subBits == $past(grpWrSubBits))
    else $error("split point not stored");

  a_group_only: assert property (@(posedge clock) disable iff (!nrst)
    excOut.req && $past(handlerActive) |-> $past(refBestGrp) < $past(refActGrp))
    else $error("preemption without higher group");

  a_sub_order: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) && !$past(handlerActive) && $past(st_reg.pend[16]) && $past(st_reg.pend[17])
    && $past(st_reg.prio[17]) < $past(st_reg.prio[16]) |-> excOut.vec != VEC_IRQ0)
    else $error("lower subpriority not served first");

  // Reference agreement and pending bookkeeping
  a_ref_winner: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) |-> excOut.vec == $past(refVec) && excOut.req == $past(refReq))
    else $error("winner differs from reference");

  a_ack_clears: assert property (@(posedge clock) disable iff (!nrst)
    ackEn && ackVec < VEC_W'(NVEC) && !raise[ackVec] |=> !st_reg.pend[$past(ackVec)])
    else $error("acknowledged vector still pending");

  a_pend_kept: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) && $past(st_reg.pend[VEC_IRQ0]) && !$past(ackEn) |-> st_reg.pend[VEC_IRQ0])
    else $error("pending line 0 dropped without ack");

  a_base_aligned: assert property (@(posedge clock) disable iff (!nrst)
    (st_reg.base & ~BASE_ALIGN_MASK) == '0 && st_reg.base <= BASE_MAX)
    else $error("table base off grid or out of range");

  a_hard_over_cfg: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) && $past(st_reg.pend[VEC_HARD]) && !$past(handlerActive)
    |-> excOut.vec <= VEC_HARD)
    else $error("configurable exception beat hard fault");

  a_no_req_idle: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) && $past(st_reg.pend) == '0 |-> !excOut.req)
    else $error("request with nothing pending");

  a_prio_write: assert property (@(posedge clock) disable iff (!nrst)
    prioWr.en && prioWr.vec < VEC_W'(NVEC) && PROG_MASK[prioWr.vec]
    |=> st_reg.prio[$past(prioWr.vec)] == $past(prioWr.prio))
    else $error("priority write not stored");

  c_irq_taken: cover property (@(posedge clock) disable iff (!nrst)
    excOut.req && excOut.vec >= VEC_IRQ0);
  c_preempt: cover property (@(posedge clock) disable iff (!nrst)
    $past(handlerActive) && excOut.req);
  c_blocked: cover property (@(posedge clock) disable iff (!nrst)
    handlerActive && found && bestGrp == actGrp);
  c_relocated: cover property (@(posedge clock) disable iff (!nrst)
    st_reg.base != BASE_RESET && excOut.req);
  c_tie_break: cover property (@(posedge clock) disable iff (!nrst)
    st_reg.pend[VEC_IRQ0] && st_reg.pend[17] && st_reg.prio[VEC_IRQ0] == st_reg.prio[17]);

endmodule

// File: tb/epvs_core_model.sv
`timescale 1ns/10ps
module epvs_core_model (
  input wire logic clock,
  input wire logic autoAck,
  input wire epvs_pkg::epvs_exc_t excOut,
  output logic ackEn,
  output logic [epvs_pkg::VEC_W-1:0] ackVec
);
  import epvs_pkg::*;

  logic armed;

  //==========================================================
  // Arming on the rising edge keeps the falling-edge drive race free
  always @(posedge clock) begin
    armed <= autoAck;
  end

  // Core side: takes whatever vector is requested, on the falling edge
  // fetch from offered address
  // handler words are software's; the core assumes bit 0 set
  always @(negedge clock) begin
    ackEn <= armed && excOut.req;
    // Idle vector is the inverse of the offered one, never a match
    ackVec <= excOut.req ? excOut.vec : ~excOut.vec;
  end
endmodule

// File: tb/exception_priority_vector_select_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h want %h", $time, (a), (e)); end end
module exception_priority_vector_select_test;
  import epvs_pkg::*;
  logic clock, nrst, ackEn, handlerActive, grpWrEn, autoAck;
  logic [NSYS-1:0] sysRaise;
  logic [NIRQ-1:0] irqLines;
  logic [VEC_W-1:0] ackVec, activeVec;
  logic [1:0] grpWrSubBits;
  epvs_prio_wr_t prioWr;
  epvs_base_wr_t baseWr;
  epvs_exc_t excOut;
  logic [31:0] stackPtrAddr;
  logic [NVEC-1:0] pendingOut;
  int n_fail, n_checks, cycles;
  epvs_core epvs_core_i (.clock(clock), .nrst(nrst), .sysRaise(sysRaise), .irqLines(irqLines),
    .ackEn(ackEn), .ackVec(ackVec), .handlerActive(handlerActive), .activeVec(activeVec),
    .prioWr(prioWr), .baseWr(baseWr), .grpWrEn(grpWrEn), .grpWrSubBits(grpWrSubBits),
    .excOut(excOut), .stackPtrAddr(stackPtrAddr), .pendingOut(pendingOut));
  epvs_core_model epvs_core_model_i (.clock(clock), .autoAck(autoAck), .excOut(excOut),
    .ackEn(ackEn), .ackVec(ackVec));
  //==========================================================
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  //==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic set_prio(input logic [5:0] v, input logic [2:0] p);
    @(negedge clock) prioWr = '{1'b1, v, p};
    @(negedge clock) prioWr.en = 1'b0;
  endtask
  task automatic set_base(input logic pv, input logic [31:0] d);
    @(negedge clock) baseWr = '{1'b1, pv, d};
    @(negedge clock) baseWr.en = 1'b0;
  endtask
  // Two edges from raise to request
  task automatic raise(input logic [NIRQ-1:0] m);
    @(negedge clock) irqLines = irqLines | m;
    cyc(2);
  endtask
  // Core acks everything for 30 cycles, then nothing may be left pending
  task automatic drain();
    @(negedge clock);
    irqLines = '0;
    sysRaise = '0;
    handlerActive = 1'b0;
    autoAck = 1'b1;
    cyc(30);
    autoAck = 1'b0;
    cyc(3);
    `CHK(pendingOut, 46'h0)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //==========================================================
  // Scenarios
  task automatic t_reset();
    `CHK(stackPtrAddr, 32'h0000_0000)
    `CHK(excOut, 39'h0)
    raise(30'h0000_0001);
    `CHK(excOut, epvs_exc_t'{1'b1, 6'h10, 32'h0000_0040})
    drain();
    $display("test reset done");
  endtask
  task automatic t_arb();
    set_prio(6'h10, 3'h5);
    set_prio(6'h11, 3'h2);
    raise(30'h0000_0203);
    `CHK(excOut.vec, 6'h11)
    `CHK(pendingOut[25], 1'b0)
    set_prio(6'h11, 3'h5);
    cyc(1);
    `CHK(excOut.vec, 6'h10)
    @(negedge clock) sysRaise = 16'h000C;
    cyc(2);
    `CHK(excOut.vec, 6'h02)
    set_prio(6'h02, 3'h7);
    @(negedge clock) sysRaise = 16'h0008;
    cyc(2);
    `CHK(excOut.vec, 6'h02)
    drain();
    $display("test arbitration done");
  endtask
  task automatic t_base();
    set_base(1'b0, 32'h0000_0400);
    `CHK(stackPtrAddr, 32'h0000_0000)
    set_base(1'b1, 32'h4000_0000);
    `CHK(stackPtrAddr, 32'h0000_0000)
    set_base(1'b1, 32'h3FFF_FF00);
    `CHK(stackPtrAddr, 32'h3FFF_FF00)
    raise(30'h0000_0004);
    `CHK(excOut.addr, 32'h3FFF_FF48)
    set_base(1'b1, 32'h0000_0100);
    cyc(1);
    `CHK(excOut.addr, 32'h0000_0148)
    drain();
    $display("test base done");
  endtask
  task automatic t_preempt();
    @(negedge clock) handlerActive = 1'b1;
    activeVec = 6'h11;
    set_prio(6'h12, 3'h5);
    raise(30'h0000_0004);
    `CHK(excOut.req, 1'b0)
    `CHK(pendingOut[18], 1'b1)
    set_prio(6'h12, 3'h4);
    cyc(1);
    `CHK(excOut, epvs_exc_t'{1'b1, 6'h12, 32'h0000_0148})
    drain();
    $display("test preempt done");
  endtask
  task automatic t_group();
    @(negedge clock) grpWrEn = 1'b1;
    grpWrSubBits = 2'h1;
    @(negedge clock) grpWrEn = 1'b0;
    handlerActive = 1'b1;
    activeVec = 6'h11;
    set_prio(6'h12, 3'h5);
    set_prio(6'h13, 3'h4);
    raise(30'h0000_000C);
    `CHK(excOut.req, 1'b0)
    @(negedge clock) handlerActive = 1'b0;
    cyc(2);
    `CHK(excOut, epvs_exc_t'{1'b1, 6'h13, 32'h0000_014C})
    drain();
    $display("test group done");
  endtask
  // Mid-run reset must undo base and priorities
  task automatic t_rereset();
    @(negedge clock) nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(1);
    `CHK(stackPtrAddr, 32'h0000_0000)
    raise(30'h0000_000C);
    `CHK(excOut, epvs_exc_t'{1'b1, 6'h12, 32'h0000_0048})
    drain();
    $display("test rereset done");
  endtask
  //==========================================================
  // Main sequence
  initial begin
    n_fail = 0;
    n_checks = 0;
    cycles = 0;
    nrst = 1'b0;
    sysRaise = '0;
    irqLines = '0;
    handlerActive = 1'b0;
    activeVec = 6'h00;
    grpWrEn = 1'b0;
    grpWrSubBits = 2'h0;
    autoAck = 1'b0;
    prioWr = '0;
    baseWr = '0;
    cyc(4);
    nrst = 1'b1;
    cyc(1);
    t_reset();
    t_arb();
    t_base();
    t_preempt();
    t_group();
    t_rereset();
    complete_run();
  end
endmodule
